// *** pmc_top.sv ***
// module: power mode controller top with ahb-lite register slave
//
// How it works
// RULE1: oscillators follow the selected mode automatically
// RULE2: gated peripherals wake at once on demand
// RULE3: active: both cores run, bank access split
// RULE4: unused peripheral clocks gated in active mode
// RULE5: bank three as co_core instruction cache
// RULE6: sleep: cores asleep, peripherals and dma on
// RULE7: low power: main core, banks 0-1 retained
// RULE8: low power: co_core keeps peripherals, banks 2-3
// RULE9: low power return skips system initialization
// RULE10: low power: dma reaches flash
// RULE11: low power: primary oscillator optionally off
// RULE12: micro power: all retained, accelerator quadrants off
// RULE13: micro power: pins held, some oscillators off
// RULE14: micro power: serial, watchdog, comparators wake
// RULE15: standby: everything retained, crystal and ring run
// RULE16: backup: cores, peripherals off, two oscillators
// RULE17: backup: per-bank and accelerator memory retention
// RULE18: sleep left on peripheral interrupt or reset pin
// RULE19: standby, backup: rtc, timer, pins, comparator
// RULE20: mode entered only after requesting core idles
// RULE21: wake restarts oscillators, waits, restores cores
`timescale 1ns/1ps
`default_nettype none

module pmc_top #(
	parameter int N_PERIPH    = 8,
	parameter int IDLE_CYC    = 16,
	parameter int SETTLE_CYC  = pmc_pkg::OSC_SETTLE_CYC,
	parameter int INIT_CYC    = pmc_pkg::INIT_CYC
) (
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	// ahb-lite slave
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic      [31:0]           hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	// core idle status, same clock domain
	input  wire logic                  main_core_idle_in,
	input  wire logic                  co_core_idle_in,
	// peripheral activity, same clock domain
	input  wire logic [N_PERIPH-1:0]   periph_request_in,
	// wake sources from pins and always-on blocks
	input  wire pmc_pkg::pmc_wake_t    wake_in,
	// domain controls
	output pmc_pkg::pmc_osc_t          osc_en_out,
	output pmc_pkg::pmc_dom_t          dom_out,
	output logic      [N_PERIPH-1:0]   periph_clk_en_out,
	output logic                       sys_init_out
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0]          ctrl;
		logic [31:0]          retain;
		logic [31:0]          wake_en;
		pmc_pkg::pmc_wake_t   wake_seen;
		pmc_pkg::pmc_state_t  fsm;
		pmc_pkg::pmc_mode_t   mode;
		logic [15:0]          count;
		logic                 dph_valid;
		logic                 dph_write;
		logic [7:0]           dph_addr;
		logic [31:0]          rdata;
		pmc_pkg::pmc_osc_t    osc;
		pmc_pkg::pmc_dom_t    dom;
		logic                 sys_init;
	} pmc_state_struct_t;

	pmc_state_struct_t st;
	pmc_state_struct_t next_st;

	// wake pins come from other domains: two-stage synchroniser
	pmc_pkg::pmc_wake_t wake_meta;
	pmc_pkg::pmc_wake_t wake_sync;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_meta <= '0;
			wake_sync <= '0;
		end else begin
			wake_meta <= wake_in;
			wake_sync <= wake_meta;
		end
	end

	// ----------------------------------------
	// mode tables
	// ----------------------------------------
	function automatic pmc_pkg::pmc_osc_t osc_for(input pmc_pkg::pmc_mode_t m, input logic pri_off);
		pmc_pkg::pmc_osc_t o;
		o = '{default: 1'b1};
		case (m)
			pmc_pkg::MODE_LOW: begin
				o.primary_osc = ~pri_off; // RULE11
			end
			pmc_pkg::MODE_MICRO: begin
				o.primary_osc   = 1'b0; // RULE13
				o.secondary_osc = 1'b0;
			end
			pmc_pkg::MODE_STBY, pmc_pkg::MODE_BACKUP: begin
				o.primary_osc   = 1'b0; // RULE15 RULE16
				o.secondary_osc = 1'b0;
				o.baud_osc      = 1'b0;
			end
			default: begin
				o = '{default: 1'b1};
			end
		endcase
		return o;
	endfunction

	function automatic pmc_pkg::pmc_dom_t dom_for(input pmc_pkg::pmc_mode_t m, input logic [31:0] c,
			input logic [31:0] r);
		pmc_pkg::pmc_dom_t d;
		d = '0;
		d.main_core_power       = 1'b1;
		d.co_core_power         = 1'b1;
		d.bank_power            = 4'hf;
		d.periph_power          = 1'b1;
		d.acc_quad_power        = c[pmc_pkg::CTRL_ACC_QUAD_BIT];
		d.acc_mem_retain        = c[pmc_pkg::CTRL_ACC_MEM_BIT];
		d.main_core_bank_access = 4'hf; // RULE3
		d.co_core_bank_access   = 4'hc; // RULE3
		d.co_core_icache        = c[pmc_pkg::CTRL_ICACHE_BIT];
		case (m)
			pmc_pkg::MODE_ACTIVE: begin
				d.main_core_run    = 1'b1; // RULE3
				d.co_core_run      = 1'b1;
				d.dma_enable       = 1'b1;
				d.co_periph_access = 1'b1;
			end
			pmc_pkg::MODE_SLEEP: begin
				d.co_core_icache = 1'b0; // RULE6
				d.dma_enable     = 1'b1; // RULE6
			end
			pmc_pkg::MODE_LOW: begin
				d.main_core_retain      = 1'b1; // RULE7
				d.bank_retain           = 4'h3; // RULE7
				d.main_core_bank_access = 4'h0;
				d.co_core_run           = 1'b1; // RULE8
				d.co_periph_access      = 1'b1; // RULE8
				d.dma_enable            = 1'b1;
				d.dma_flash             = 1'b1; // RULE10
			end
			pmc_pkg::MODE_MICRO, pmc_pkg::MODE_STBY: begin
				d.main_core_retain      = 1'b1; // RULE12 RULE15
				d.co_core_retain        = 1'b1;
				d.bank_retain           = 4'hf;
				d.main_core_bank_access = 4'h0;
				d.co_core_bank_access   = 4'h0;
				d.co_core_icache        = 1'b0;
				d.acc_quad_power        = 1'b0; // RULE12
				d.acc_mem_retain        = r[pmc_pkg::RETAIN_ACC_MEM_BIT];
				d.periph_retain         = 1'b1; // RULE13
				d.pin_hold              = 1'b1; // RULE13
			end
			pmc_pkg::MODE_BACKUP: begin
				d.main_core_power       = 1'b0; // RULE16
				d.co_core_power         = 1'b0;
				d.periph_power          = 1'b0;
				d.bank_power            = r[3:0]; // RULE17
				d.bank_retain           = r[3:0]; // RULE17
				d.main_core_bank_access = 4'h0;
				d.co_core_bank_access   = 4'h0;
				d.co_core_icache        = 1'b0;
				d.acc_quad_power        = 1'b0;
				d.acc_mem_retain        = r[pmc_pkg::RETAIN_ACC_MEM_BIT]; // RULE17
			end
			default: begin
				d.main_core_run = 1'b1;
			end
		endcase
		if (d.co_core_icache) begin
			d.co_core_bank_access[3] = 1'b0; // RULE5
		end
		return d;
	endfunction

	function automatic logic wake_hit(input pmc_pkg::pmc_mode_t m, input pmc_pkg::pmc_wake_t w,
			input logic [15:0] en);
		logic [15:0] q;
		q = w & en;
		case (m)
			pmc_pkg::MODE_SLEEP: begin
				wake_hit = q[15] | q[3]; // RULE18
			end
			pmc_pkg::MODE_LOW: begin
				wake_hit = q[15] | q[14] | q[13] | q[12] | (|q[11:8]) | q[4] | q[3] | q[2]; // RULE18
			end
			pmc_pkg::MODE_MICRO: begin
				wake_hit = q[15] | q[14] | q[13] | q[12] | (|q[11:8]) | (|q[7:5]); // RULE14
			end
			pmc_pkg::MODE_STBY, pmc_pkg::MODE_BACKUP: begin
				wake_hit = q[15] | q[14] | q[13] | q[12] | q[8]; // RULE19
			end
			default: begin
				wake_hit = 1'b0;
			end
		endcase
		// the reset pin wakes from every mode regardless of the enable mask
		wake_hit = wake_hit | w.ext_reset;
	endfunction

	// ----------------------------------------
	// dynamic clock gating
	// ----------------------------------------
	logic gate_enable;
	assign gate_enable = (st.fsm == pmc_pkg::ST_RUN) || (st.mode == pmc_pkg::MODE_SLEEP)
		|| (st.mode == pmc_pkg::MODE_LOW);

	pmc_clk_gate #(
		.N    (N_PERIPH),
		.IDLE (IDLE_CYC)
	) u_gate (
		.clock_in   (clock_in),
		.rst_n_in   (rst_n_in),
		.enable_in  (gate_enable),
		.request_in (periph_request_in),
		.clk_en_out (periph_clk_en_out)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic       addr_ok;
	logic       req;
	logic [2:0] tgt;

	assign req     = hsel_in && htrans_in[1] && hready_in;
	assign addr_ok = haddr_in[7:4] == 4'h0 && haddr_in[31:8] == 24'h0;
	assign tgt     = st.ctrl[pmc_pkg::CTRL_MODE_LSB +: 3];

	always_comb begin
		next_st           = st;
		next_st.dph_valid = req && addr_ok;
		next_st.dph_write = hwrite_in;
		next_st.dph_addr  = haddr_in[7:0];
		next_st.ctrl[pmc_pkg::CTRL_GO_BIT] = 1'b0;
		// bus write in data phase
		if (st.dph_valid && st.dph_write) begin
			case (st.dph_addr)
				pmc_pkg::CTRL_ADDR: begin
					next_st.ctrl = {23'h0, hwdata_in[8:0]}; // RULE20
				end
				pmc_pkg::RETAIN_ADDR: begin
					next_st.retain = {27'h0, hwdata_in[4:0]};
				end
				pmc_pkg::WAKE_ADDR: begin
					next_st.wake_en = {16'h0, hwdata_in[15:0]};
				end
				default: begin
					next_st.wake_seen = st.wake_seen & ~hwdata_in[15:0];
				end
			endcase
		end
		// read data captured at address phase
		case (haddr_in[7:0])
			pmc_pkg::CTRL_ADDR:   next_st.rdata = st.ctrl;
			pmc_pkg::RETAIN_ADDR: next_st.rdata = st.retain;
			pmc_pkg::WAKE_ADDR:   next_st.rdata = st.wake_en;
			pmc_pkg::STATUS_ADDR: next_st.rdata = {st.wake_seen, 8'h0, 2'h0, 3'(st.fsm), st.mode};
			default:              next_st.rdata = 32'h0;
		endcase
		// captured wake events: set wins over a software clear in the same cycle
		next_st.wake_seen = next_st.wake_seen | wake_sync;
		if (st.count != 16'h0) begin
			next_st.count = st.count - 16'h1;
		end
		case (st.fsm)
			pmc_pkg::ST_RUN: begin
				if (st.ctrl[pmc_pkg::CTRL_GO_BIT] && tgt != 3'h0 && tgt <= 3'h5) begin
					next_st.fsm  = pmc_pkg::ST_WAIT_IDLE;
					next_st.mode = pmc_pkg::pmc_mode_t'(tgt);
				end
			end
			pmc_pkg::ST_WAIT_IDLE: begin
				if (main_core_idle_in && (st.mode != pmc_pkg::MODE_SLEEP || co_core_idle_in)) begin
					next_st.fsm = pmc_pkg::ST_LOWPWR; // RULE20
					next_st.dom = dom_for(st.mode, st.ctrl, st.retain);
					next_st.osc = osc_for(st.mode, st.ctrl[pmc_pkg::CTRL_PRI_OFF_BIT]); // RULE1
				end
			end
			pmc_pkg::ST_LOWPWR: begin
				if (wake_hit(st.mode, wake_sync, st.wake_en[15:0])) begin
					next_st.fsm   = pmc_pkg::ST_OSC_WAKE;
					next_st.osc   = osc_for(pmc_pkg::MODE_ACTIVE, 1'b0); // RULE21 RULE1
					next_st.count = 16'(SETTLE_CYC);
				end
			end
			pmc_pkg::ST_OSC_WAKE: begin
				if (st.count == 16'h0) begin
					next_st.dom  = dom_for(pmc_pkg::MODE_ACTIVE, st.ctrl, st.retain); // RULE21
					if (st.mode == pmc_pkg::MODE_BACKUP) begin
						next_st.fsm      = pmc_pkg::ST_INIT;
						next_st.sys_init = 1'b1;
						next_st.count    = 16'(INIT_CYC);
						next_st.dom.main_core_run = 1'b0;
						next_st.dom.co_core_run   = 1'b0;
					end else begin
						next_st.fsm  = pmc_pkg::ST_RUN; // RULE9
						next_st.mode = pmc_pkg::MODE_ACTIVE;
					end
				end
			end
			pmc_pkg::ST_INIT: begin
				if (st.count == 16'h0) begin
					next_st.fsm      = pmc_pkg::ST_RUN;
					next_st.mode     = pmc_pkg::MODE_ACTIVE;
					next_st.sys_init = 1'b0;
					next_st.dom      = dom_for(pmc_pkg::MODE_ACTIVE, st.ctrl, st.retain);
				end
			end
			default: begin
				next_st.fsm = pmc_pkg::ST_RUN;
			end
		endcase
		if (st.fsm == pmc_pkg::ST_RUN) begin
			next_st.dom = dom_for(pmc_pkg::MODE_ACTIVE, st.ctrl, st.retain); // RULE3 RULE5
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st           <= '0;
			st.ctrl      <= pmc_pkg::CTRL_RESET;
			st.retain    <= pmc_pkg::RETAIN_RESET;
			st.wake_en   <= pmc_pkg::WAKE_RESET;
			st.fsm       <= pmc_pkg::ST_RUN;
			st.mode      <= pmc_pkg::MODE_ACTIVE;
			st.osc       <= '1;
			st.dom       <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata_out    = st.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign osc_en_out    = st.osc;
	assign dom_out       = st.dom;
	assign sys_init_out  = st.sys_init;

endmodule : pmc_top // pmc_top

`default_nettype wire

// *** pmc_pkg.sv ***
// package: shared constants, types and register map of the power mode controller
package pmc_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] RETAIN_ADDR = 8'h04;
	localparam logic [7:0] WAKE_ADDR   = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0c;

	// ----------------------------------------
	// ctrl fields
	// ----------------------------------------
	localparam int CTRL_MODE_LSB      = 0;
	localparam int CTRL_PRI_OFF_BIT   = 4;
	localparam int CTRL_ICACHE_BIT    = 5;
	localparam int CTRL_ACC_QUAD_BIT  = 6;
	localparam int CTRL_ACC_MEM_BIT   = 7;
	localparam int CTRL_GO_BIT        = 8;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_00c0;
	localparam logic [31:0] RETAIN_RESET = 32'h0000_001f;
	localparam logic [31:0] WAKE_RESET   = 32'h0000_ffff;

	// retain fields: bits 3:0 banks zero..three, bit 4 accelerator memory
	localparam int RETAIN_ACC_MEM_BIT = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ         = 20;
	localparam int OSC_SETTLE_US   = 10;
	localparam int OSC_SETTLE_CYC  = OSC_SETTLE_US * CLK_MHZ;
	localparam int INIT_US         = 50;
	localparam int INIT_CYC        = INIT_US * CLK_MHZ;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'h0,
		MODE_SLEEP  = 3'h1,
		MODE_LOW    = 3'h2,
		MODE_MICRO  = 3'h3,
		MODE_STBY   = 3'h4,
		MODE_BACKUP = 3'h5
	} pmc_mode_t;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAIT_IDLE,
		ST_LOWPWR,
		ST_OSC_WAKE,
		ST_INIT
	} pmc_state_t;

	// oscillator enables
	typedef struct packed {
		logic primary_osc;
		logic secondary_osc;
		logic baud_osc;
		logic crystal_time_osc;
		logic nano_ring_osc;
	} pmc_osc_t;

	// per-domain power/clock controls
	typedef struct packed {
		logic       main_core_run;
		logic       main_core_retain;
		logic       main_core_power;
		logic       co_core_run;
		logic       co_core_retain;
		logic       co_core_power;
		logic [3:0] bank_power;
		logic [3:0] bank_retain;
		logic [3:0] main_core_bank_access;
		logic [3:0] co_core_bank_access;
		logic       co_core_icache;
		logic       acc_quad_power;
		logic       acc_mem_retain;
		logic       periph_power;
		logic       periph_retain;
		logic       pin_hold;
		logic       dma_enable;
		logic       dma_flash;
		logic       co_periph_access;
	} pmc_dom_t;

	// wake sources, one bit each except four comparator bits and two spare bits
	typedef struct packed {
		logic        ext_reset;
		logic        rtc;
		logic        wakeup_timer;
		logic        pins;
		logic [3:0]  comparator;
		logic        lowpower_serial_zero;
		logic        lowpower_serial_one;
		logic        windowed_watchdog_one;
		logic        co_core;
		logic        periph_irq;
		logic        lpm_periph;
		logic [1:0]  spare;
	} pmc_wake_t;

endpackage : pmc_pkg

// *** pmc_clk_gate.sv ***
// module: per-peripheral dynamic clock gating with fast on-demand wake
`timescale 1ns/1ps
`default_nettype none

module pmc_clk_gate #(
	parameter int N    = 8,
	parameter int IDLE = 16
) (
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire logic         enable_in,
	input  wire logic [N-1:0] request_in,
	output logic      [N-1:0] clk_en_out
);

	typedef struct packed {
		logic [N-1:0]      en;
		logic [N-1:0][7:0] idle;
	} pmc_cg_t;

	pmc_cg_t st;
	pmc_cg_t next_st;

	// ----------------------------------------
	// idle timers
	// ----------------------------------------
	always_comb begin
		next_st = st;
		for (int i = 0; i < N; i++) begin
			if (!enable_in || request_in[i]) begin
				next_st.en[i]   = 1'b1; // RULE2 RULE4
				next_st.idle[i] = 8'h00;
			end else if (st.idle[i] == 8'(IDLE)) begin
				next_st.en[i] = 1'b0; // RULE4
			end else begin
				next_st.idle[i] = st.idle[i] + 8'h01;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '{en: '1, idle: '0};
		end else begin
			st <= next_st;
		end
	end

	// wake request passes through combinationally so a gated peripheral resumes at once
	assign clk_en_out = st.en | request_in; // RULE2

endmodule : pmc_clk_gate // pmc_clk_gate

`default_nettype wire

// *** pmc_checker.sv ***
// checker: concurrent assertions on the power mode controller ports
`timescale 1ns/1ps
`default_nettype none

module pmc_checker #(
	parameter int N_PERIPH   = 8,
	parameter int SETTLE_CYC = 4
) (
	input wire logic                clock_in,
	input wire logic                rst_n_in,
	input wire logic [N_PERIPH-1:0] periph_request_in,
	input wire logic [N_PERIPH-1:0] periph_clk_en_out,
	input wire pmc_pkg::pmc_osc_t   osc_en_out,
	input wire pmc_pkg::pmc_dom_t   dom_out,
	input wire logic                sys_init_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// saturating count of cycles with every oscillator on
	logic [9:0] on_cnt;
	logic       stopped;
	logic       was_backup;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			on_cnt     <= 10'h000;
			stopped    <= 1'b0;
			was_backup <= 1'b0;
		end else begin
			if (osc_en_out != 5'h1f)
				on_cnt <= 10'h000;
			else if (on_cnt != 10'h3ff)
				on_cnt <= on_cnt + 10'h001;
			if ($fell(dom_out.main_core_run))
				stopped <= 1'b1;
			if (!dom_out.main_core_power && osc_en_out == 5'h03)
				was_backup <= 1'b1;
			else if ($fell(sys_init_out))
				was_backup <= 1'b0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_req_gates_on: assert property ((periph_request_in & ~periph_clk_en_out) == '0)
		else $error("requested clock off");
	a_gate_off_idle: assert property ($fell(periph_clk_en_out[0]) |-> !$past(periph_request_in[0]))
		else $error("clock gated while requested");
	a_active_split: assert property (dom_out.main_core_run && dom_out.co_core_run
		|-> dom_out.main_core_bank_access == 4'hf && dom_out.co_core_bank_access[1:0] == 2'h0)
		else $error("bank access split wrong");
	a_icache_bank: assert property (dom_out.co_core_run
		|-> dom_out.co_core_bank_access[3] != dom_out.co_core_icache)
		else $error("bank three access vs cache");
	a_sleep_keeps: assert property (!dom_out.main_core_run && !dom_out.co_core_run && dom_out.main_core_power
		&& !dom_out.main_core_retain && !sys_init_out |-> dom_out.periph_power && dom_out.dma_enable)
		else $error("sleep lost peripherals");
	a_low_keeps: assert property (dom_out.main_core_retain && dom_out.co_core_run |-> dom_out.bank_retain[1:0] == 2'h3
		&& dom_out.co_periph_access && dom_out.dma_flash && osc_en_out[3:0] == 4'hf)
		else $error("low power domains wrong");
	a_deep_entry: assert property ($rose(dom_out.pin_hold) |-> !osc_en_out.primary_osc && !osc_en_out.secondary_osc
		&& osc_en_out[1:0] == 2'h3 && !dom_out.acc_quad_power && dom_out.co_core_retain)
		else $error("deep mode entry wrong");
	a_backup_entry: assert property ($fell(dom_out.main_core_power)
		|-> osc_en_out == 5'h03 && !dom_out.co_core_power && !dom_out.periph_power)
		else $error("backup entry wrong");
	a_init_backup: assert property (sys_init_out |-> was_backup)
		else $error("init outside backup return");
	a_wake_settle: assert property ($rose(dom_out.main_core_run) && stopped |-> on_cnt >= SETTLE_CYC - 1)
		else $error("core back before settle");

	c_deep: cover property ($rose(dom_out.pin_hold));
	c_init: cover property ($rose(sys_init_out));
	c_gate: cover property ($fell(periph_clk_en_out[0]));
endmodule // pmc_checker

bind pmc_top pmc_checker #(.N_PERIPH(N_PERIPH), .SETTLE_CYC(SETTLE_CYC)) u_chk (
	.clock_in(clock_in), .rst_n_in(rst_n_in), .periph_request_in(periph_request_in),
	.periph_clk_en_out(periph_clk_en_out), .osc_en_out(osc_en_out), .dom_out(dom_out),
	.sys_init_out(sys_init_out));

`default_nettype wire

// *** pmc_core_model.sv ***
// model: both cores reaching their wait state on software request
`timescale 1ns/1ps
`default_nettype none

module pmc_core_model (
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       sleep_req_in,
	input  wire logic [3:0] delay_in,
	output logic            main_core_idle_out,
	output logic            co_core_idle_out
);
	logic [3:0] cnt;
	// co core idles one cycle after the main core, so sleep waits for both
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt                <= 4'h0;
			main_core_idle_out <= 1'b0;
			co_core_idle_out   <= 1'b0;
		end else if (!sleep_req_in) begin
			cnt                <= 4'h0;
			main_core_idle_out <= 1'b0;
			co_core_idle_out   <= 1'b0;
		end else if (cnt != delay_in) begin
			cnt <= cnt + 4'h1;
		end else begin
			main_core_idle_out <= 1'b1;
			co_core_idle_out   <= main_core_idle_out;
		end
	end
endmodule // pmc_core_model

`default_nettype wire

// *** power_mode_controller_tb.sv ***
// testbench: register bus, mode entry and wake of the power mode controller
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller_tb;
	logic               clock_in, rst_n_in, hsel, hwrite, hready, hresp, sys_init;
	logic               sleep_req, mc_idle, cc_idle, rd_ph, rnd_on, saw_init;
	logic [1:0]         htrans;
	logic [31:0]        haddr, hwdata, hrdata;
	logic [3:0]         delay;
	logic [4:0]         ret;
	logic [7:0]         preq, clk_en;
	logic [15:0]        wk;
	pmc_pkg::pmc_wake_t wake;
	pmc_pkg::pmc_osc_t  osc, eo, mo;
	pmc_pkg::pmc_dom_t  dom, ed, md;
	logic [31:0]        exp_q[$], msk_q[$];
	integer             seed = 32'h333a5102;
	int                 fails, samples_checked, cyc;

	pmc_top #(.SETTLE_CYC(4), .INIT_CYC(8)) uut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .main_core_idle_in(mc_idle), .co_core_idle_in(cc_idle),
		.periph_request_in(preq), .wake_in(wake), .osc_en_out(osc), .dom_out(dom),
		.periph_clk_en_out(clk_en), .sys_init_out(sys_init));
	pmc_core_model u_cores (.clock_in(clock_in), .rst_n_in(rst_n_in), .sleep_req_in(sleep_req),
		.delay_in(delay), .main_core_idle_out(mc_idle), .co_core_idle_out(cc_idle));

	// ----------------------------------------
	// checking and reporting
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// read data stands through the data phase and is taken at the edge that closes it
	always @(posedge clock_in)
		if (rd_ph && exp_q.size() > 0) begin
			chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
			chk("hresp", 32'(hresp), 32'h0);
		end

	always @(posedge clock_in) begin
		cyc++;
		if (sys_init === 1'b1)
			saw_init <= 1'b1;
		if (rnd_on)
			preq <= 8'($random(seed));
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clock_in); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph  <= !wr;
		do @(posedge clock_in); while (hready !== 1'b1);
		rd_ph  <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wait_run(input logic v, input int lim);
		for (int i = 0; i < lim && dom.main_core_run !== v; i++)
			@(posedge clock_in);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst_n_in, hsel, hwrite, sleep_req, rd_ph, rnd_on, saw_init} = '0;
		{htrans, haddr, hwdata, preq, wake} = '0;
		delay = 4'h1;
		repeat (5) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET, 32'hffffffff);
		rd(pmc_pkg::RETAIN_ADDR, pmc_pkg::RETAIN_RESET, 32'hffffffff);
		rd(pmc_pkg::WAKE_ADDR, pmc_pkg::WAKE_RESET, 32'hffffffff);
		bus(1'b1, 8'h10, seed);
		rd(8'h10, 32'h0, 32'hffffffff);
		ret = 5'($random(seed));
		bus(1'b1, pmc_pkg::RETAIN_ADDR, 32'(ret));
		rd(pmc_pkg::RETAIN_ADDR, 32'(ret), 32'hffffffff);
		chk("osc_act", 32'(osc), 32'h1f);
		chk("bank_co", 32'(dom.co_core_bank_access), 32'hc);
		bus(1'b1, pmc_pkg::CTRL_ADDR, 32'h0e0);
		repeat (2) @(posedge clock_in);
		chk("icache", 32'(dom.co_core_bank_access), 32'h4);
		bus(1'b1, pmc_pkg::CTRL_ADDR, 32'h0c0);
		$display("registers done");
		rnd_on <= 1'b1;
		repeat (50) @(posedge clock_in);
		rnd_on <= 1'b0;
		@(posedge clock_in);
		preq <= 8'h00;
		repeat (24) @(posedge clock_in);
		chk("gated", 32'(clk_en), 32'h0);
		preq <= 8'h10;
		repeat (2) @(posedge clock_in);
		chk("ungated", 32'(clk_en), 32'h10);
		preq <= 8'h00;
		$display("gating done");
		for (int m = 1; m <= 5; m++) begin
			md = '0;
			mo = 5'h1f;
			if (m == 1) begin
				{md.main_core_run, md.co_core_run, md.periph_power, md.dma_enable} = 4'hf;
				ed = md;
				{ed.main_core_run, ed.co_core_run} = 2'h0;
				eo = 5'h1f;
				wk = 16'h0008;
			end else if (m == 2) begin
				{md.main_core_retain, md.co_core_run, md.co_periph_access, md.dma_flash} = 4'hf;
				md.bank_retain = 4'h3;
				md.co_core_bank_access = 4'hf;
				ed = md;
				ed.co_core_bank_access = 4'hc;
				eo = 5'h0f;
				wk = 16'h0010;
			end else if (m < 5) begin
				{md.main_core_retain, md.co_core_retain, md.acc_quad_power, md.pin_hold} = 4'hf;
				md.bank_retain = 4'hf;
				md.periph_retain = (m == 4);
				ed = md;
				ed.acc_quad_power = 1'b0;
				eo = (m == 3) ? 5'h07 : 5'h03;
				wk = (m == 3) ? 16'h0080 : 16'h0100;
			end else begin
				{md.main_core_power, md.co_core_power, md.periph_power, md.acc_mem_retain} = 4'hf;
				md.bank_retain = 4'hf;
				ed = '0;
				ed.bank_retain = ret[3:0];
				ed.acc_mem_retain = ret[4];
				eo = 5'h03;
				wk = 16'h4000;
			end
			// slow cores on the first pass show the wait for idle
			delay <= (m == 1) ? 4'hc : 4'h1;
			bus(1'b1, pmc_pkg::CTRL_ADDR, 32'h1c0 | 32'(m) | ((m == 2) ? 32'h10 : 32'h0));
			sleep_req <= 1'b1;
			saw_init  <= 1'b0;
			repeat (5) @(posedge clock_in);
			if (m == 1)
				chk("held", 32'(dom.main_core_run), 32'h1);
			wait_run(1'b0, 60);
			repeat (3) @(posedge clock_in);
			chk("dom", 32'(dom & md), 32'(ed));
			chk("osc", 32'(osc & mo), 32'(eo));
			rd(pmc_pkg::STATUS_ADDR, 32'(m) | (32'(pmc_pkg::ST_LOWPWR) << 3), 32'h3f);
			// micro power: a masked serial wake must not end the mode; standby ignores it anyway
			if (m >= 3) begin
				if (m == 3)
					bus(1'b1, pmc_pkg::WAKE_ADDR, 32'hff7f);
				wake <= 16'h0080;
				repeat (20) @(posedge clock_in);
				chk("stay", 32'(dom.main_core_run), 32'h0);
				if (m == 3)
					bus(1'b1, pmc_pkg::WAKE_ADDR, pmc_pkg::WAKE_RESET);
			end
			wake <= wk;
			wait_run(1'b1, 100);
			wake      <= 16'h0;
			sleep_req <= 1'b0;
			repeat (12) @(posedge clock_in);
			chk("woke", 32'(dom.main_core_run), 32'h1);
			chk("init", 32'(saw_init), 32'(m == 5));
			$display("mode %0d done", m);
		end
		// every wake source used above stays recorded until software clears it
		rd(pmc_pkg::STATUS_ADDR, 32'h4198_0000, 32'hffff_0000);
		$display("sticky wake done");
		final_report();
	end
endmodule // power_mode_controller_tb

`default_nettype wire
